// ---- hdl/lfpm_monitor.sv ----
/*
 * Load feedback position monitor: scales load increments into load position, aligns it to motor
 * position, watches the unfiltered difference, filters difference and load speed.
 * Assumes one control-cycle strobe, motor position and load increments from same-clock logic,
 * and homing/command/acknowledge events as one-cycle pulses.
 */
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
module lfpm_monitor
	import lfpm_pkg::*;
#(
	parameter int          POS_W = 32,
	parameter logic [15:0] ERR_ID = 16'h0000 // Arbitrary instance code, unused by logic
) (
	input  wire logic              core_clk_i,      // 200 MHz clock
	input  wire logic              rst_i,           // Synchronous reset, high
	input  wire logic [7:0]        reg_addr_i,      // Register byte address
	input  wire logic [31:0]       reg_wdata_i,     // Write data
	input  wire logic              reg_wr_i,        // Write strobe
	input  wire logic              reg_rd_i,        // Read strobe
	output logic      [31:0]       reg_rdata_o,     // Read data, cycle after strobe
	input  wire logic              ctrl_cycle_i,    // Control cycle strobe
	input  wire logic signed [POS_W-1:0] motor_pos_i, // Motor position
	input  wire logic signed [15:0] load_incr_i,    // Load increments since last cycle
	input  wire logic              download_done_i, // Configuration download complete
	input  wire logic              settings_valid_trigger_i, // Make settings valid
	input  wire logic              homing_start_i,  // Machine zero run started
	input  wire logic              homing_done_i,   // Zero position reached
	input  wire logic              pos_cmd_start_i, // New positioning command
	input  wire logic              err_ack_i,       // Error acknowledge
	output logic                   use_load_pos_o,  // Controller uses load position
	output logic signed [POS_W-1:0] load_pos_o,     // Load position to controller
	output logic                   error_o,         // Excess difference error
	output logic      [15:0]       error_code_o     // Error code
);
	typedef struct packed {
		logic [31:0] thresh;
		logic [15:0] enable;
		logic [31:0] dfilt_t;
		logic [15:0] sfilt_t;
		logic [4:0]  dsh;
		logic [4:0]  ssh;
		logic [4:0]  cfg;
		logic [31:0] incr;
		logic [31:0] tnum;
		logic [31:0] tden;
		logic [31:0] scale;
		logic signed [POS_W-1:0] lpos;
		logic signed [POS_W-1:0] dfilt;
		logic [31:0] peak;
		logic signed [31:0] spd;
		logic signed [31:0] sfilt;
		logic        active;
		logic        err;
		logic        homing;
		logic        pend_align;
		logic        up;
		logic [31:0] rdata;
		logic [15:0] ecode;
	} lfpm_state_t;
	lfpm_state_t s_r, s_nxt;
	logic signed [POS_W-1:0] diff_raw;
	logic [31:0]             diff_mag;
	logic signed [63:0]      prod;
	logic signed [63:0]      step;
	logic signed [15:0]      dir_incr;
	logic                    align;
	logic                    go_active;
	logic                    excess;
	logic [15:0]             status_w;
	logic [31:0]             den_safe;
	always_comb begin
		s_nxt = s_r;
		diff_raw = s_r.lpos - motor_pos_i;
		diff_mag = diff_raw[POS_W-1] ? 32'(-diff_raw) : 32'(diff_raw);
		excess = s_r.active && (diff_mag > s_r.thresh);
		// Direction reversal for rotary and linear sources
		dir_incr = s_r.cfg[LFPM_CFG_REVERSE] ? -load_incr_i : load_incr_i;
		den_safe = (s_r.tden == 32'h0) ? LFPM_ONE_32 : s_r.tden;
		// Rotary: travel num/(den*incr); linear: incr holds distance per period
		prod = 64'(dir_incr) * $signed({1'b0, s_r.tnum}) * $signed({1'b0, s_r.scale});
		if (s_r.cfg[LFPM_CFG_LINEAR]) begin
			step = (64'(dir_incr) * $signed({1'b0, s_r.incr}) * $signed({1'b0, s_r.scale})) >>> 16;
		end else begin
			step = (prod / $signed({1'b0, den_safe})) / $signed({1'b0, (s_r.incr == 32'h0) ? LFPM_ONE_32
				: s_r.incr}) >>> 16;
		end
		go_active = 1'b0;
		align = 1'b0;
		if (reg_wr_i && reg_addr_i == LFPM_ADDR_THRESH) begin
			s_nxt.thresh = reg_wdata_i;
		end else if (reg_wr_i && reg_addr_i == LFPM_ADDR_DFILT_TIME) begin
			s_nxt.dfilt_t = reg_wdata_i;
		end else if (reg_wr_i && reg_addr_i == LFPM_ADDR_SFILT_TIME) begin
			s_nxt.sfilt_t = reg_wdata_i[15:0];
		end else if (reg_wr_i && reg_addr_i == LFPM_ADDR_CONFIG) begin
			s_nxt.cfg = reg_wdata_i[4:0];
		end else if (reg_wr_i && reg_addr_i == LFPM_ADDR_INCR) begin
			s_nxt.incr = reg_wdata_i;
		end else if (reg_wr_i && reg_addr_i == LFPM_ADDR_TRAV_NUM) begin
			s_nxt.tnum = reg_wdata_i;
		end else if (reg_wr_i && reg_addr_i == LFPM_ADDR_TRAV_DEN) begin
			s_nxt.tden = reg_wdata_i;
		end else if (reg_wr_i && reg_addr_i == LFPM_ADDR_SCALE) begin
			s_nxt.scale = reg_wdata_i;
		end else if (reg_wr_i && reg_addr_i == LFPM_ADDR_ENABLE) begin
			s_nxt.enable = reg_wdata_i[15:0];
			if (reg_wdata_i[15:0] == LFPM_ENABLE_ON) begin
				go_active = 1'b1;
			end
		end else if (reg_wr_i && reg_addr_i == LFPM_ADDR_COMMAND && reg_wdata_i[15:0] == LFPM_CMD_ALIGN) begin
			align = 1'b1;
		end
		if (settings_valid_trigger_i) begin
			s_nxt.dsh = s_r.dfilt_t[4:0];
			s_nxt.ssh = s_r.sfilt_t[4:0];
		end
		if (download_done_i && s_r.cfg[LFPM_CFG_FEAT_ON]) begin
			go_active = 1'b1;
		end
		if (err_ack_i && s_r.err) begin
			go_active = 1'b1;
		end
		if (homing_start_i) begin
			s_nxt.homing = 1'b1;
		end
		if (homing_done_i && s_r.homing) begin
			s_nxt.homing = 1'b0;
			go_active = 1'b1;
			align = 1'b1;
		end
		if (pos_cmd_start_i && s_r.cfg[LFPM_CFG_CONT_MODE]) begin
			align = 1'b1;
		end
		if (!s_r.up) begin
			s_nxt.up = 1'b1;
			align = 1'b1;
		end
		// During homing activation waits for completion
		if (go_active && s_nxt.homing && !homing_done_i) begin
			s_nxt.pend_align = 1'b1;
			go_active = 1'b0;
		end
		if (go_active) begin
			s_nxt.err = 1'b0;
			if (!s_r.active) begin
				align = 1'b1;
			end
			s_nxt.active = 1'b1;
			s_nxt.pend_align = 1'b0;
		end
		if (s_nxt.homing) begin
			s_nxt.active = 1'b0;
		end
		if (ctrl_cycle_i && s_r.cfg[LFPM_CFG_SRC_EN]) begin
			s_nxt.lpos = s_r.lpos + POS_W'(step);
			s_nxt.spd = 32'(step);
			s_nxt.sfilt = s_r.sfilt + ((32'(step) - s_r.sfilt) >>> s_r.ssh);
			s_nxt.dfilt = s_r.dfilt + ((diff_raw - s_r.dfilt) >>> s_r.dsh);
		end
		// Peak takes the live difference one clock later, so it never reads below the previous clock's raw value except after an alignment clears it
		if (diff_mag > s_r.peak) begin
			s_nxt.peak = diff_mag;
		end
		if (excess && !go_active) begin
			s_nxt.err = 1'b1;
			s_nxt.active = 1'b0;
		end
		if (align) begin
			s_nxt.lpos = motor_pos_i;
			s_nxt.dfilt = '0;
			s_nxt.peak = '0;
		end
		s_nxt.ecode = s_nxt.err ? LFPM_ERR_EXCESS : 16'h0000;
		status_w = '0;
		status_w[LFPM_ST_ACTIVE] = s_r.active;
		status_w[LFPM_ST_ERROR] = s_r.err;
		status_w[LFPM_ST_HOMING] = s_r.homing;
		status_w[LFPM_ST_SRC] = s_r.cfg[LFPM_CFG_SRC_EN];
		s_nxt.rdata = LFPM_RD_UNMAPPED;
		if (!reg_rd_i) begin
			s_nxt.rdata = LFPM_RD_UNMAPPED;
		end else if (reg_addr_i == LFPM_ADDR_THRESH) begin
			s_nxt.rdata = s_r.thresh;
		end else if (reg_addr_i == LFPM_ADDR_LOAD_POS) begin
			s_nxt.rdata = 32'(s_r.lpos);
		end else if (reg_addr_i == LFPM_ADDR_DIFF_RAW) begin
			s_nxt.rdata = 32'(diff_raw);
		end else if (reg_addr_i == LFPM_ADDR_DIFF_FILT) begin
			s_nxt.rdata = 32'(s_r.dfilt);
		end else if (reg_addr_i == LFPM_ADDR_DIFF_PEAK) begin
			s_nxt.rdata = s_r.peak;
		end else if (reg_addr_i == LFPM_ADDR_SPD_RAW) begin
			s_nxt.rdata = s_r.spd;
		end else if (reg_addr_i == LFPM_ADDR_SPD_FILT) begin
			s_nxt.rdata = s_r.sfilt;
		end else if (reg_addr_i == LFPM_ADDR_ENABLE) begin
			s_nxt.rdata = {16'h0, s_r.enable};
		end else if (reg_addr_i == LFPM_ADDR_DFILT_TIME) begin
			s_nxt.rdata = s_r.dfilt_t;
		end else if (reg_addr_i == LFPM_ADDR_STATUS) begin
			s_nxt.rdata = {{16{status_w[15]}}, status_w};
		end else if (reg_addr_i == LFPM_ADDR_SFILT_TIME) begin
			s_nxt.rdata = {16'h0, s_r.sfilt_t};
		end else if (reg_addr_i == LFPM_ADDR_CONFIG) begin
			s_nxt.rdata = {27'h0, s_r.cfg};
		end else if (reg_addr_i == LFPM_ADDR_INCR) begin
			s_nxt.rdata = s_r.incr;
		end else if (reg_addr_i == LFPM_ADDR_TRAV_NUM) begin
			s_nxt.rdata = s_r.tnum;
		end else if (reg_addr_i == LFPM_ADDR_TRAV_DEN) begin
			s_nxt.rdata = s_r.tden;
		end else if (reg_addr_i == LFPM_ADDR_SCALE) begin
			s_nxt.rdata = s_r.scale;
		end else if (reg_addr_i == LFPM_ADDR_ERR_CODE) begin
			s_nxt.rdata = {16'h0, s_r.ecode};
		end else if (reg_addr_i == LFPM_ADDR_ACTIVE_CFG) begin
			s_nxt.rdata = {27'h0, s_r.dsh};
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			s_r <= '0;
			s_r.thresh <= LFPM_THRESH_RST;
			s_r.tnum <= LFPM_ONE_32;
			s_r.tden <= LFPM_ONE_32;
			s_r.incr <= LFPM_ONE_32;
			s_r.scale <= LFPM_SCALE_UNITY;
			s_r.dsh <= LFPM_TIME_RST;
			s_r.ssh <= LFPM_TIME_RST;
		end else begin
			s_r <= s_nxt;
		end
	end
	always_comb begin
		reg_rdata_o = s_r.rdata;
		use_load_pos_o = s_r.active;
		load_pos_o = s_r.lpos;
		error_o = s_r.err;
		error_code_o = s_r.ecode;
	end
	property p_err_code;
		@(posedge core_clk_i) disable iff (rst_i)
		error_o |-> (error_code_o == LFPM_ERR_EXCESS) && !use_load_pos_o;
	endproperty
	a_err_code: assert property (p_err_code) else $error("error without code or still active");
	property p_excess;
		@(posedge core_clk_i) disable iff (rst_i)
		(use_load_pos_o && (diff_mag > s_r.thresh) && !reg_wr_i && !download_done_i && !homing_done_i)
			|=> error_o && !use_load_pos_o;
	endproperty
	a_excess: assert property (p_excess) else $error("excess difference not flagged");
	property p_drop;
		@(posedge core_clk_i) disable iff (rst_i)
		$rose(error_o) |-> $fell(use_load_pos_o);
	endproperty
	a_drop: assert property (p_drop) else $error("load position kept after error");
	property p_cmd;
		@(posedge core_clk_i) disable iff (rst_i)
		(reg_wr_i && reg_addr_i == LFPM_ADDR_COMMAND && reg_wdata_i[15:0] == LFPM_CMD_ALIGN)
			|=> (load_pos_o == $past(motor_pos_i)) && (s_r.peak == 32'h0);
	endproperty
	a_cmd: assert property (p_cmd) else $error("align command ignored");
	property p_rise;
		@(posedge core_clk_i) disable iff (rst_i)
		$rose(use_load_pos_o) |-> (load_pos_o == $past(motor_pos_i));
	endproperty
	a_rise: assert property (p_rise) else $error("activation without alignment");
	property p_homing;
		@(posedge core_clk_i) disable iff (rst_i)
		s_r.homing |-> !use_load_pos_o;
	endproperty
	a_homing: assert property (p_homing) else $error("active during homing");
	property p_download;
		@(posedge core_clk_i) disable iff (rst_i)
		(download_done_i && s_r.cfg[LFPM_CFG_FEAT_ON] && !s_nxt.homing && !excess) |=> use_load_pos_o;
	endproperty
	a_download: assert property (p_download) else $error("download did not enable");
	property p_vp;
		@(posedge core_clk_i) disable iff (rst_i)
		!settings_valid_trigger_i |=> (s_r.dsh == $past(s_r.dsh)) && (s_r.ssh == $past(s_r.ssh));
	endproperty
	a_vp: assert property (p_vp) else $error("filter time changed without settings valid");
	property p_cont;
		@(posedge core_clk_i) disable iff (rst_i)
		(pos_cmd_start_i && s_r.cfg[LFPM_CFG_CONT_MODE]) |=> (load_pos_o == $past(motor_pos_i));
	endproperty
	a_cont: assert property (p_cont) else $error("continuous mode did not align");
	property p_power;
		@(posedge core_clk_i) disable iff (rst_i)
		$fell(rst_i) |=> (load_pos_o == $past(motor_pos_i));
	endproperty
	a_power: assert property (p_power) else $error("no alignment after switch-on");
	property p_ack;
		@(posedge core_clk_i) disable iff (rst_i)
		(err_ack_i && error_o && !s_r.homing && !homing_start_i) |=> use_load_pos_o && !error_o;
	endproperty
	a_ack: assert property (p_ack) else $error("acknowledge did not restore load control");
	property p_enable;
		@(posedge core_clk_i) disable iff (rst_i)
		(reg_wr_i && reg_addr_i == LFPM_ADDR_ENABLE && reg_wdata_i[15:0] == LFPM_ENABLE_ON && !s_r.homing
			&& !homing_start_i) |=> use_load_pos_o && !error_o;
	endproperty
	a_enable: assert property (p_enable) else $error("enable write did not restore load control");
	property p_pend;
		@(posedge core_clk_i) disable iff (rst_i)
		s_r.pend_align |-> !use_load_pos_o;
	endproperty
	a_pend: assert property (p_pend) else $error("activation not deferred during homing");
	property p_homing_done;
		@(posedge core_clk_i) disable iff (rst_i)
		(homing_done_i && s_r.homing) |=> use_load_pos_o && (load_pos_o == $past(motor_pos_i));
	endproperty
	a_homing_done: assert property (p_homing_done) else $error("homing end did not align and enable");
	property p_peak;
		@(posedge core_clk_i) disable iff (rst_i)
		!align |=> (s_r.peak >= $past(diff_mag)) && (s_r.peak >= $past(s_r.peak));
	endproperty
	a_peak: assert property (p_peak) else $error("peak difference lost");
	property p_rd_idle;
		@(posedge core_clk_i) disable iff (rst_i)
		!reg_rd_i |=> (reg_rdata_o == LFPM_RD_UNMAPPED);
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
	property p_rd_pos;
		@(posedge core_clk_i) disable iff (rst_i)
		(reg_rd_i && reg_addr_i == LFPM_ADDR_LOAD_POS) |=> (reg_rdata_o == 32'($past(load_pos_o)));
	endproperty
	a_rd_pos: assert property (p_rd_pos) else $error("load position read wrong");
	property p_status;
		@(posedge core_clk_i) disable iff (rst_i)
		(reg_rd_i && reg_addr_i == LFPM_ADDR_STATUS) |=> (reg_rdata_o[LFPM_ST_ACTIVE] == $past(use_load_pos_o))
			&& (reg_rdata_o[LFPM_ST_ERROR] == $past(error_o));
	endproperty
	a_status: assert property (p_status) else $error("status word wrong");
	property p_hold;
		@(posedge core_clk_i) disable iff (rst_i)
		(!ctrl_cycle_i && !align) |=> $stable(load_pos_o);
	endproperty
	a_hold: assert property (p_hold) else $error("load position moved outside control cycle");
	property p_err_hold;
		@(posedge core_clk_i) disable iff (rst_i)
		(error_o && !err_ack_i && !download_done_i && !reg_wr_i && !homing_done_i) |=> error_o;
	endproperty
	a_err_hold: assert property (p_err_hold) else $error("error cleared without re-activation");
	property p_sfilt;
		@(posedge core_clk_i) disable iff (rst_i)
		settings_valid_trigger_i |=> (s_r.ssh == $past(s_r.sfilt_t[4:0])) && (s_r.dsh == $past(s_r.dfilt_t[4:0]));
	endproperty
	a_sfilt: assert property (p_sfilt) else $error("filter times not taken on settings valid");
	property p_inactive;
		@(posedge core_clk_i) disable iff (rst_i)
		(!use_load_pos_o && !error_o) |=> !error_o;
	endproperty
	a_inactive: assert property (p_inactive) else $error("error raised while inactive");
endmodule : lfpm_monitor

// ---- hdl/lfpm_pkg.sv ----
/*
 * Constants for the load feedback position monitor: register offsets, field positions,
 * reset values and codes.
 * Assumes a register port with byte addresses of aligned 32-bit words.
 */
package lfpm_pkg;
	localparam logic [7:0]  LFPM_ADDR_THRESH     = 8'h00;
	localparam logic [7:0]  LFPM_ADDR_LOAD_POS   = 8'h04;
	localparam logic [7:0]  LFPM_ADDR_DIFF_RAW   = 8'h08;
	localparam logic [7:0]  LFPM_ADDR_DIFF_FILT  = 8'h0C;
	localparam logic [7:0]  LFPM_ADDR_DIFF_PEAK  = 8'h10;
	localparam logic [7:0]  LFPM_ADDR_SPD_RAW    = 8'h14;
	localparam logic [7:0]  LFPM_ADDR_SPD_FILT   = 8'h18;
	localparam logic [7:0]  LFPM_ADDR_COMMAND    = 8'h1C;
	localparam logic [7:0]  LFPM_ADDR_ENABLE     = 8'h20;
	localparam logic [7:0]  LFPM_ADDR_DFILT_TIME = 8'h24;
	localparam logic [7:0]  LFPM_ADDR_STATUS     = 8'h28;
	localparam logic [7:0]  LFPM_ADDR_SFILT_TIME = 8'h2C;
	localparam logic [7:0]  LFPM_ADDR_CONFIG     = 8'h30;
	localparam logic [7:0]  LFPM_ADDR_INCR       = 8'h34;
	localparam logic [7:0]  LFPM_ADDR_TRAV_NUM   = 8'h38;
	localparam logic [7:0]  LFPM_ADDR_TRAV_DEN   = 8'h3C;
	localparam logic [7:0]  LFPM_ADDR_SCALE      = 8'h40;
	localparam logic [7:0]  LFPM_ADDR_ERR_CODE   = 8'h44;
	localparam logic [7:0]  LFPM_ADDR_ACTIVE_CFG = 8'h48;
	// Config register fields
	localparam int          LFPM_CFG_SRC_EN      = 0;
	localparam int          LFPM_CFG_LINEAR      = 1;
	localparam int          LFPM_CFG_REVERSE     = 2;
	localparam int          LFPM_CFG_CONT_MODE   = 3;
	localparam int          LFPM_CFG_FEAT_ON     = 4;
	// Status word fields
	localparam int          LFPM_ST_ACTIVE       = 0;
	localparam int          LFPM_ST_ERROR        = 1;
	localparam int          LFPM_ST_HOMING       = 2;
	localparam int          LFPM_ST_SRC          = 3;
	localparam logic [15:0] LFPM_CMD_ALIGN       = 16'h0001;
	localparam logic [15:0] LFPM_ENABLE_ON       = 16'h0001;
	localparam logic [15:0] LFPM_ERR_EXCESS      = 16'h7385;
	localparam logic [31:0] LFPM_SCALE_UNITY     = 32'h0001_0000;
	localparam logic [31:0] LFPM_ONE_32          = 32'h0000_0001;
	localparam logic [31:0] LFPM_THRESH_RST      = 32'h7FFF_FFFF;
	localparam logic [31:0] LFPM_RD_UNMAPPED     = 32'h0000_0000;
	localparam logic [4:0]  LFPM_TIME_RST        = 5'h04;
endpackage : lfpm_pkg

// ---- dv/lfpm_sensor_model.sv ----
/*
 * Load-side sensor stand-in: hands the increment count chosen by the bench to the monitor.
 * Assumes the monitor samples increments only while ctrl_cycle_i is high.
 */
`timescale 1ns/1ps
module lfpm_sensor_model (
	input  wire logic signed [15:0] step_i,       // Increments per control cycle
	input  wire logic               ctrl_cycle_i, // Control cycle strobe
	output logic signed [15:0]      load_incr_o   // Increments to the monitor
);
	// Outside a control cycle the count is stale, so show its inverse
	assign load_incr_o = ctrl_cycle_i ? step_i : ~step_i;
endmodule : lfpm_sensor_model

// ---- dv/lfpm_monitor_bench.sv ----
/*
 * Self-checking bench for the load feedback position monitor.
 * Assumes the register map and field positions of lfpm_pkg and a 200 MHz core clock.
 */
`timescale 1ns/1ps
module lfpm_monitor_bench;
	import lfpm_pkg::*;
	logic               clk = 1'b0;
	logic               rst = 1'b1;
	logic [7:0]         addr = 8'h00;
	logic [31:0]        wdata = 32'h0;
	logic               wr = 1'b0;
	logic               rd = 1'b0;
	logic [31:0]        rdata;
	logic               cyc = 1'b0;
	logic signed [31:0] motor = 32'sh64;
	logic signed [15:0] step = 16'sh0;
	logic signed [15:0] incr;
	logic [5:0]         ev = 6'h00;
	logic               use_o;
	logic signed [31:0] lpos;
	logic               err;
	logic [15:0]        ecode;
	int                 fails = 0;
	int                 checked = 0;

	always #2.5 clk = ~clk;

	lfpm_sensor_model i_sensor (.step_i(step), .ctrl_cycle_i(cyc), .load_incr_o(incr));
	lfpm_monitor i_dut (
		.core_clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_rdata_o(rdata), .ctrl_cycle_i(cyc), .motor_pos_i(motor),
		.load_incr_i(incr), .download_done_i(ev[0]), .settings_valid_trigger_i(ev[1]),
		.homing_start_i(ev[2]), .homing_done_i(ev[3]), .pos_cmd_start_i(ev[4]), .err_ack_i(ev[5]),
		.use_load_pos_o(use_o), .load_pos_o(lpos), .error_o(err), .error_code_o(ecode));

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask : wr_reg

	task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1;
		chk(name, rdata, exp);
	endtask : rd_chk

	task automatic pulse(input int k);
		@(posedge clk);
		ev[k] <= 1'b1;
		@(posedge clk);
		ev[k] <= 1'b0;
		@(posedge clk);
		#1;
	endtask : pulse

	task automatic cycles(input int n, input logic signed [15:0] s);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			step <= s;
			cyc  <= 1'b1;
			@(posedge clk);
			cyc <= 1'b0;
		end
		@(posedge clk);
		#1;
	endtask : cycles

	task automatic t_power;
		chk("load_pos", lpos, 32'h0000_0064);
		chk("use_load", use_o, 1'b0);
		rd_chk("threshold", LFPM_ADDR_THRESH, LFPM_THRESH_RST);
		rd_chk("scale", LFPM_ADDR_SCALE, LFPM_SCALE_UNITY);
		rd_chk("unmapped", 8'h4C, LFPM_RD_UNMAPPED);
		wr_reg(LFPM_ADDR_LOAD_POS, 32'h0000_0055);
		rd_chk("ro_load_pos", LFPM_ADDR_LOAD_POS, 32'h0000_0064);
		wr_reg(LFPM_ADDR_DFILT_TIME, 32'h0000_0007);
		rd_chk("shift_before", LFPM_ADDR_ACTIVE_CFG, 32'h0000_0004);
		pulse(1);
		rd_chk("shift_after", LFPM_ADDR_ACTIVE_CFG, 32'h0000_0007);
		$display("test power done");
	endtask : t_power

	task automatic t_track;
		wr_reg(LFPM_ADDR_CONFIG, 32'h0000_0003);
		wr_reg(LFPM_ADDR_INCR, 32'h0000_0001);
		cycles(4, 16'sh3);
		chk("linear_pos", lpos, 32'h0000_0070);
		rd_chk("diff_raw", LFPM_ADDR_DIFF_RAW, 32'h0000_000C);
		rd_chk("peak", LFPM_ADDR_DIFF_PEAK, 32'h0000_000C);
		rd_chk("speed_raw", LFPM_ADDR_SPD_RAW, 32'h0000_0003);
		rd_chk("speed_filt", LFPM_ADDR_SPD_FILT, 32'h0000_0003);
		wr_reg(LFPM_ADDR_CONFIG, 32'h0000_0007);
		cycles(2, 16'sh3);
		chk("reversed_pos", lpos, 32'h0000_006A);
		rd_chk("speed_rev", LFPM_ADDR_SPD_RAW, 32'hFFFF_FFFD);
		wr_reg(LFPM_ADDR_COMMAND, {16'h0, LFPM_CMD_ALIGN});
		@(posedge clk);
		#1;
		chk("aligned_pos", lpos, 32'h0000_0064);
		rd_chk("peak_cleared", LFPM_ADDR_DIFF_PEAK, 32'h0);
		wr_reg(LFPM_ADDR_CONFIG, 32'h0000_0001);
		wr_reg(LFPM_ADDR_INCR, 32'h0000_0003);
		wr_reg(LFPM_ADDR_TRAV_NUM, 32'h0000_0006);
		wr_reg(LFPM_ADDR_TRAV_DEN, 32'h0000_0001);
		cycles(1, 16'sh3);
		chk("rotary_pos", lpos, 32'h0000_006A);
		wr_reg(LFPM_ADDR_SCALE, 32'h0002_0000);
		cycles(1, 16'sh3);
		chk("scaled_pos", lpos, 32'h0000_0076);
		$display("test track done");
	endtask : t_track

	task automatic t_error;
		wr_reg(LFPM_ADDR_SCALE, LFPM_SCALE_UNITY);
		wr_reg(LFPM_ADDR_INCR, 32'h0000_0001);
		wr_reg(LFPM_ADDR_THRESH, 32'h0000_0005);
		wr_reg(LFPM_ADDR_CONFIG, 32'h0000_0013);
		pulse(0);
		chk("active", use_o, 1'b1);
		chk("activation_align", lpos, 32'h0000_0064);
		cycles(1, 16'sh3);
		chk("below_thresh", err, 1'b0);
		cycles(1, 16'sh3);
		chk("error", err, 1'b1);
		chk("code", ecode, LFPM_ERR_EXCESS);
		chk("fallback", use_o, 1'b0);
		rd_chk("status", LFPM_ADDR_STATUS, 32'h0000_000A);
		rd_chk("code_reg", LFPM_ADDR_ERR_CODE, {16'h0, LFPM_ERR_EXCESS});
		pulse(5);
		chk("ack_active", use_o, 1'b1);
		chk("ack_error", err, 1'b0);
		chk("ack_diff", lpos, 32'h0000_0064);
		cycles(2, 16'sh3);
		wr_reg(LFPM_ADDR_ENABLE, {16'h0, LFPM_ENABLE_ON});
		@(posedge clk);
		#1;
		chk("enable_active", use_o, 1'b1);
		chk("enable_code", ecode, 16'h0000);
		$display("test error done");
	endtask : t_error

	task automatic t_modes;
		pulse(2);
		chk("homing_off", use_o, 1'b0);
		pulse(0);
		chk("homing_defer", use_o, 1'b0);
		@(posedge clk);
		motor <= 32'sh0;
		pulse(3);
		chk("homing_on", use_o, 1'b1);
		chk("homing_pos", lpos, 32'h0);
		cycles(1, 16'sh2);
		pulse(4);
		chk("single_cmd", lpos, 32'h0000_0002);
		wr_reg(LFPM_ADDR_CONFIG, 32'h0000_001B);
		pulse(4);
		chk("cont_cmd", lpos, 32'h0);
		$display("test modes done");
	endtask : t_modes

	task automatic close_out;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : close_out

	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		t_power();
		t_track();
		t_error();
		t_modes();
		close_out();
	end

	initial begin
		#50000;
		fails++;
		close_out();
	end
endmodule : lfpm_monitor_bench
